/* rtl/pbs_cfg.svh */
// Constants for the PID standby and burst pipe supervisor.
// Assumes 100 MHz clk_i; the header is included by its bare name.
//
// Overview of operation
// [RULE1] Display value is feedback times scale factor
// [RULE2] Restart error level register, default 5.0%
// [RULE3] Leave standby when error exceeds restart level
// [RULE4] Enter standby after speed low for delay
// [RULE5] Zero standby delay disables standby entry
// [RULE6] Source zero plus digital select uses preset
// [RULE7] Nonzero prime time starts timer on enable
// [RULE8] Timer expiry without threshold trips pressure low
// [RULE9] Threshold compare inverts in inverse PID mode
// [RULE10] Threshold met stops timer; disable clears it
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH
`define PBS_ADR_CTRL 8'h00
`define PBS_ADR_SCALE 8'h04
`define PBS_ADR_RESTART 8'h08
`define PBS_ADR_SBY_SPEED 8'h0C
`define PBS_ADR_SBY_DELAY 8'h10
`define PBS_ADR_PRESET 8'h14
`define PBS_ADR_PRIME 8'h18
`define PBS_ADR_BURST 8'h1C
`define PBS_ADR_REF_SRC 8'h20
`define PBS_ADR_MAX_SPEED 8'h24
`define PBS_ADR_STATUS 8'h28
`define PBS_ADR_DISPLAY 8'h2C
`define PBS_CTRL_PID_EN 0
`define PBS_CTRL_INVERSE 1
`define PBS_CTRL_TRIP_CLR 2
`define PBS_RST_SCALE 16'h03E8
`define PBS_RST_RESTART 16'h0032
`define PBS_RST_MAX_SPEED 16'h01F4
`define PBS_RST_ZERO 16'h0000
`define PBS_SCALE_MAX 16'hC350
`define PBS_PCT_MAX 16'h03E8
`define PBS_PRIME_MAX 16'h0258
`define PBS_FAULT_PRESSURE_LOW 8'h01
`define PBS_TICK_MS 100
`define PBS_CLK_MHZ 100
`define PBS_TENTHS_PER_S 16'h000A
`endif

/* rtl/pbs_pkg.sv */
// Types for the PID standby and burst pipe supervisor.
// Assumes nothing beyond a SystemVerilog compiler.
package pbs_pkg;
    typedef enum logic [1:0]
    {
        PBS_IDLE = 2'b00,
        PBS_RUN = 2'b01,
        PBS_STANDBY = 2'b10,
        PBS_TRIP = 2'b11
    } pbs_state_t;
endpackage

/* rtl/pbs_supervisor.sv */
// PID standby, set-point select, display scaling and burst pipe supervisor.
// Assumes speed, reference and feedback come from logic on clk_i; ref2_sel_i is a pin.
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "pbs_cfg.svh"
module pbs_supervisor #(
    parameter int TICK_CYCLES = `PBS_TICK_MS * 1000 * `PBS_CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] motor_speed_i,
    input wire logic [15:0] pid_ref_i,
    input wire logic [15:0] pid_fb_i,
    input wire logic ref2_sel_i,
    output logic [15:0] pid_ref_o,
    output logic [31:0] display_o,
    output logic standby_o,
    output logic pressure_low_trip_o,
    output logic [7:0] fault_code_o
);
    // Limits clamp writes so out-of-range software values cannot break the timers
    function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lim);
        clamp16 = (v[31:16] != 16'h0000 || v[15:0] > lim) ? lim : v[15:0];
    endfunction

    pbs_pkg::pbs_state_t state_ff, nxt_state;
    logic ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    logic pid_en_ff, nxt_pid_en, inverse_ff, nxt_inverse;
    logic [15:0] scale_ff, nxt_scale, restart_ff, nxt_restart, sby_speed_ff, nxt_sby_speed;
    logic [15:0] sby_delay_ff, nxt_sby_delay, preset_ff, nxt_preset, prime_ff, nxt_prime;
    logic [15:0] burst_ff, nxt_burst, max_speed_ff, nxt_max_speed;
    logic [3:0] ref_src_ff, nxt_ref_src;
    logic [31:0] tick_cnt_ff, nxt_tick_cnt;
    logic tick;
    logic [15:0] sby_cnt_ff, nxt_sby_cnt, prime_cnt_ff, nxt_prime_cnt;
    logic priming_ff, nxt_priming, standby_ff, nxt_standby, trip_ff, nxt_trip;
    logic sync1_ff, sync2_ff;
    logic [15:0] nxt_pid_ref;
    logic [31:0] nxt_display;
    logic [7:0] nxt_fault;
    logic wr, rd_req, thr_met, speed_low, restart_hit, trip_clr;
    logic [15:0] eff_thr;
    logic signed [16:0] err;

    always_comb
    begin
        rd_req = wb_cyc_i && wb_stb_i && !ack_ff;
        // Writes land on the edge where the master sees ack
        wr = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && (wb_sel_i != 4'h0);
        tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
        nxt_tick_cnt = tick ? 32'h0 : tick_cnt_ff + 32'h1;
        nxt_ack = rd_req;
        nxt_pid_ref = (ref_src_ff == 4'h0 && sync2_ff) ? preset_ff : pid_ref_i; // [RULE6]
        nxt_display = 32'(pid_fb_i) * 32'(scale_ff); // [RULE1]
        eff_thr = (sby_speed_ff > max_speed_ff) ? max_speed_ff : sby_speed_ff;
        speed_low = motor_speed_i < eff_thr;
        thr_met = inverse_ff ? (pid_fb_i <= burst_ff) : (pid_fb_i >= burst_ff); // [RULE9]
        err = inverse_ff ? $signed({1'b0, pid_fb_i}) - $signed({1'b0, nxt_pid_ref})
                         : $signed({1'b0, nxt_pid_ref}) - $signed({1'b0, pid_fb_i});
        restart_hit = err > $signed({1'b0, restart_ff}); // [RULE3]
        nxt_pid_en = pid_en_ff;
        nxt_inverse = inverse_ff;
        nxt_scale = scale_ff;
        nxt_restart = restart_ff;
        nxt_sby_speed = sby_speed_ff;
        nxt_sby_delay = sby_delay_ff;
        nxt_preset = preset_ff;
        nxt_prime = prime_ff;
        nxt_burst = burst_ff;
        nxt_max_speed = max_speed_ff;
        nxt_ref_src = ref_src_ff;
        trip_clr = 1'b0;
        if (wr)
        begin
            case (wb_adr_i)
                `PBS_ADR_CTRL:
                begin
                    nxt_pid_en = wb_dat_i[`PBS_CTRL_PID_EN];
                    nxt_inverse = wb_dat_i[`PBS_CTRL_INVERSE];
                    trip_clr = wb_dat_i[`PBS_CTRL_TRIP_CLR];
                end
                `PBS_ADR_SCALE: nxt_scale = clamp16(wb_dat_i, `PBS_SCALE_MAX);
                `PBS_ADR_RESTART: nxt_restart = clamp16(wb_dat_i, `PBS_PCT_MAX); // [RULE2]
                `PBS_ADR_SBY_SPEED: nxt_sby_speed = wb_dat_i[15:0];
                `PBS_ADR_SBY_DELAY: nxt_sby_delay = wb_dat_i[15:0];
                `PBS_ADR_PRESET: nxt_preset = clamp16(wb_dat_i, `PBS_PCT_MAX);
                `PBS_ADR_PRIME: nxt_prime = clamp16(wb_dat_i, `PBS_PRIME_MAX);
                `PBS_ADR_BURST: nxt_burst = clamp16(wb_dat_i, `PBS_PCT_MAX);
                `PBS_ADR_REF_SRC: nxt_ref_src = wb_dat_i[3:0];
                `PBS_ADR_MAX_SPEED: nxt_max_speed = wb_dat_i[15:0];
                default: nxt_ref_src = ref_src_ff;
            endcase
        end
        nxt_rdat = 32'h0;
        if (rd_req && !wb_we_i)
        begin
            case (wb_adr_i)
                `PBS_ADR_CTRL: nxt_rdat = {30'h0, inverse_ff, pid_en_ff};
                `PBS_ADR_SCALE: nxt_rdat = {16'h0, scale_ff};
                `PBS_ADR_RESTART: nxt_rdat = {16'h0, restart_ff};
                `PBS_ADR_SBY_SPEED: nxt_rdat = {16'h0, sby_speed_ff};
                `PBS_ADR_SBY_DELAY: nxt_rdat = {16'h0, sby_delay_ff};
                `PBS_ADR_PRESET: nxt_rdat = {16'h0, preset_ff};
                `PBS_ADR_PRIME: nxt_rdat = {16'h0, prime_ff};
                `PBS_ADR_BURST: nxt_rdat = {16'h0, burst_ff};
                `PBS_ADR_REF_SRC: nxt_rdat = {28'h0, ref_src_ff};
                `PBS_ADR_MAX_SPEED: nxt_rdat = {16'h0, max_speed_ff};
                `PBS_ADR_STATUS: nxt_rdat = {16'h0, fault_code_o, 4'h0, priming_ff, state_ff, sync2_ff};
                `PBS_ADR_DISPLAY: nxt_rdat = display_o;
                default: nxt_rdat = 32'h0;
            endcase
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_sby_cnt = sby_cnt_ff;
        nxt_prime_cnt = prime_cnt_ff;
        nxt_priming = priming_ff;
        nxt_fault = fault_code_o;
        case (state_ff)
            pbs_pkg::PBS_IDLE:
            begin
                nxt_sby_cnt = 16'h0;
                if (pid_en_ff)
                begin
                    nxt_state = pbs_pkg::PBS_RUN;
                    nxt_prime_cnt = 16'(prime_ff * `PBS_TENTHS_PER_S); // [RULE7]
                    nxt_priming = prime_ff != 16'h0; // [RULE7]
                end
            end
            pbs_pkg::PBS_RUN:
            begin
                if (!pid_en_ff)
                begin
                    nxt_state = pbs_pkg::PBS_IDLE;
                    nxt_priming = 1'b0; // [RULE10]
                    nxt_prime_cnt = 16'h0; // [RULE10]
                end
                else if (priming_ff && thr_met)
                    nxt_priming = 1'b0; // [RULE10]
                else if (priming_ff && tick && prime_cnt_ff <= 16'h1)
                begin
                    nxt_state = pbs_pkg::PBS_TRIP; // [RULE8]
                    nxt_priming = 1'b0;
                    nxt_fault = `PBS_FAULT_PRESSURE_LOW; // [RULE8]
                end
                else if (priming_ff && tick)
                    nxt_prime_cnt = prime_cnt_ff - 16'h1;
                // Standby waits until priming is over so a slow prime cannot hide a burst pipe
                if (pid_en_ff && !priming_ff)
                begin
                    if (!speed_low || sby_delay_ff == 16'h0) // [RULE5]
                        nxt_sby_cnt = 16'h0;
                    else if (tick && sby_cnt_ff + 16'h1 >= sby_delay_ff)
                    begin
                        nxt_state = pbs_pkg::PBS_STANDBY; // [RULE4]
                        nxt_sby_cnt = 16'h0;
                    end
                    else if (tick)
                        nxt_sby_cnt = sby_cnt_ff + 16'h1; // [RULE4]
                end
            end
            pbs_pkg::PBS_STANDBY:
            begin
                if (!pid_en_ff)
                    nxt_state = pbs_pkg::PBS_IDLE;
                else if (restart_hit)
                    nxt_state = pbs_pkg::PBS_RUN; // [RULE3]
            end
            pbs_pkg::PBS_TRIP:
            begin
                if (trip_clr)
                begin
                    nxt_state = pbs_pkg::PBS_IDLE;
                    nxt_fault = 8'h00;
                end
            end
            default: nxt_state = pbs_pkg::PBS_IDLE;
        endcase
        nxt_standby = nxt_state == pbs_pkg::PBS_STANDBY;
        nxt_trip = nxt_state == pbs_pkg::PBS_TRIP;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= pbs_pkg::PBS_IDLE;
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0;
            pid_en_ff <= 1'b0;
            inverse_ff <= 1'b0;
            scale_ff <= `PBS_RST_SCALE;
            restart_ff <= `PBS_RST_RESTART; // [RULE2]
            sby_speed_ff <= `PBS_RST_ZERO;
            sby_delay_ff <= `PBS_RST_ZERO;
            preset_ff <= `PBS_RST_ZERO;
            prime_ff <= `PBS_RST_ZERO;
            burst_ff <= `PBS_RST_ZERO;
            max_speed_ff <= `PBS_RST_MAX_SPEED;
            ref_src_ff <= 4'h0;
            tick_cnt_ff <= 32'h0;
            sby_cnt_ff <= 16'h0;
            prime_cnt_ff <= 16'h0;
            priming_ff <= 1'b0;
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            standby_ff <= 1'b0;
            trip_ff <= 1'b0;
            pid_ref_o <= 16'h0;
            display_o <= 32'h0;
            fault_code_o <= 8'h00;
        end
        else
        begin
            state_ff <= nxt_state;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
            pid_en_ff <= nxt_pid_en;
            inverse_ff <= nxt_inverse;
            scale_ff <= nxt_scale;
            restart_ff <= nxt_restart;
            sby_speed_ff <= nxt_sby_speed;
            sby_delay_ff <= nxt_sby_delay;
            preset_ff <= nxt_preset;
            prime_ff <= nxt_prime;
            burst_ff <= nxt_burst;
            max_speed_ff <= nxt_max_speed;
            ref_src_ff <= nxt_ref_src;
            tick_cnt_ff <= nxt_tick_cnt;
            sby_cnt_ff <= nxt_sby_cnt;
            prime_cnt_ff <= nxt_prime_cnt;
            priming_ff <= nxt_priming;
            // Digital input pin is asynchronous to clk_i
            sync1_ff <= ref2_sel_i;
            sync2_ff <= sync1_ff;
            standby_ff <= nxt_standby;
            trip_ff <= nxt_trip;
            pid_ref_o <= nxt_pid_ref;
            display_o <= nxt_display;
            fault_code_o <= nxt_fault;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign standby_o = standby_ff;
    assign pressure_low_trip_o = trip_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_sby_to_run;
        state_ff == pbs_pkg::PBS_STANDBY ##1 state_ff == pbs_pkg::PBS_RUN;
    endsequence
    sequence s_run_to_sby;
        state_ff == pbs_pkg::PBS_RUN ##1 state_ff == pbs_pkg::PBS_STANDBY;
    endsequence

    a_display_scaled: assert property (##1 display_o == 32'($past(pid_fb_i)) * 32'($past(scale_ff))) // [RULE1]
        else $error("display value not feedback times scale");
    a_restart_limit: assert property (restart_ff <= `PBS_PCT_MAX) // [RULE2]
        else $error("restart level above range");
    a_restart_cause: assert property (s_sby_to_run |-> $past(restart_hit) && $past(pid_en_ff)) // [RULE3]
        else $error("standby left without restart error");
    a_standby_cause: assert property (s_run_to_sby |-> $past(speed_low) && $past(tick)) // [RULE4]
        else $error("standby entered without low speed");
    a_zero_delay: assert property (sby_delay_ff == 16'h0 |=> !$rose(standby_o)) // [RULE5]
        else $error("standby entered with zero delay");
    a_preset_ref: assert property (ref_src_ff == 4'h0 && sync2_ff |=> pid_ref_o == $past(preset_ff)) // [RULE6]
        else $error("preset reference not used");
    a_prime_start: assert property (state_ff == pbs_pkg::PBS_IDLE && pid_en_ff |=> // [RULE7]
        priming_ff == ($past(prime_ff) != 16'h0))
        else $error("prime timer start wrong");
    a_trip_code: assert property ($rose(pressure_low_trip_o) |-> // [RULE8]
        fault_code_o == `PBS_FAULT_PRESSURE_LOW && $past(priming_ff))
        else $error("trip without pressure low code");
    a_prime_stop: assert property (state_ff == pbs_pkg::PBS_RUN && priming_ff && thr_met |=> // [RULE10]
        !priming_ff && !pressure_low_trip_o)
        else $error("threshold met but timer not stopped");
    a_disable_clear: assert property (!pid_en_ff |=> !priming_ff) // [RULE10]
        else $error("prime timer kept after disable");
    a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
endmodule

/* verif/pbs_plant.sv */
// Plant model: motor speed loop and pressure transducer beyond the supervisor.
// Assumes clk_i and rst_i come from the bench, which also sets the targets.
`timescale 1ns/1ps
module pbs_plant (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] speed_set_i,
    input wire logic [15:0] fb_set_i,
    input wire logic slow_i,
    output logic [15:0] motor_speed_o,
    output logic [15:0] pid_fb_o
);
    logic [15:0] nxt_fb;
    // Slow mode climbs one step a cycle, like a pipe that fills late
    always_comb
    begin
        nxt_fb = fb_set_i;
        if (slow_i && pid_fb_o < fb_set_i)
        begin
            nxt_fb = pid_fb_o + 16'h0001;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            motor_speed_o <= 16'h0000;
            pid_fb_o <= 16'h0000;
        end
        else
        begin
            motor_speed_o <= speed_set_i;
            pid_fb_o <= nxt_fb;
        end
    end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the PID standby and burst pipe supervisor.
// Assumes the plant model; ticks are shortened to 10 cycles.
`timescale 1ns/1ps
`include "pbs_cfg.svh"
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ref2_sel = 1'b0, slow = 1'b0, standby, trip;
    logic [7:0] adr = 8'h00, fault;
    logic [31:0] wdat = 32'h0, rdat, display;
    logic [15:0] pid_ref = 16'h0, speed_set = 16'h0, fb_set = 16'h0, speed, fb, ref_o;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 clk_i = ~clk_i;
    pbs_supervisor #(.TICK_CYCLES(10)) i_pbs_supervisor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .motor_speed_i(speed), .pid_ref_i(pid_ref), .pid_fb_i(fb), .ref2_sel_i(ref2_sel),
        .pid_ref_o(ref_o), .display_o(display), .standby_o(standby), .pressure_low_trip_o(trip),
        .fault_code_o(fault));
    pbs_plant i_pbs_plant (.clk_i(clk_i), .rst_i(rst_i), .speed_set_i(speed_set), .fb_set_i(fb_set),
        .slow_i(slow), .motor_speed_o(speed), .pid_fb_o(fb));
    task automatic stop_test;
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Run is about a thousand cycles; the ceiling leaves wide margin
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Request is held until ack is sampled; the wait is bounded, never assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("wb_ack", 32'h1, {31'h0, ack});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, exp, q);
    endtask
    task automatic t_reset;
        rd("scale", `PBS_ADR_SCALE, 32'h3E8);
        rd("restart", `PBS_ADR_RESTART, 32'h32);
        rd("max_speed", `PBS_ADR_MAX_SPEED, 32'h1F4);
        rd("unmapped", 8'h40, 32'h0);
        wr(`PBS_ADR_RESTART, 32'h7D0);
        rd("restart_clamp", `PBS_ADR_RESTART, 32'h3E8);
        wr(`PBS_ADR_RESTART, 32'h32);
    endtask
    task automatic t_display;
        fb_set <= 16'h0190;
        wr(`PBS_ADR_SCALE, 32'h9C4);
        wt(3);
        chk("display", 32'h000F4240, display);
        wr(`PBS_ADR_SCALE, 32'hEA60);
        rd("scale_clamp", `PBS_ADR_SCALE, 32'hC350);
        wt(3);
        chk("display_max", 32'h01312D00, display);
        rd("display_reg", `PBS_ADR_DISPLAY, 32'h01312D00);
    endtask
    task automatic t_preset;
        wr(`PBS_ADR_REF_SRC, 32'h0);
        wr(`PBS_ADR_PRESET, 32'h2BC);
        pid_ref <= 16'h012C;
        ref2_sel <= 1'b1;
        wt(5);
        chk("ref_preset", 32'h2BC, ref_o);
        ref2_sel <= 1'b0;
        wt(5);
        chk("ref_analog", 32'h12C, ref_o);
        ref2_sel <= 1'b1;
        wr(`PBS_ADR_REF_SRC, 32'h1);
        wt(5);
        chk("ref_src_one", 32'h12C, ref_o);
    endtask
    // Cases: direct met, inverse met, inverse unmet, direct slow fill
    task automatic t_prime;
        logic [15:0] fbv [4] = '{16'h0258, 16'h0190, 16'h0258, 16'h0258};
        logic inv [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        logic texp [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        logic slw [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
        wr(`PBS_ADR_PRIME, 32'h1);
        wr(`PBS_ADR_BURST, 32'h1F4);
        for (int i = 0; i < 4; i++)
        begin
            wr(`PBS_ADR_CTRL, 32'h0);
            slow <= slw[i];
            fb_set <= slw[i] ? 16'h0000 : fbv[i];
            wt(3);
            fb_set <= fbv[i];
            wr(`PBS_ADR_CTRL, {30'h0, inv[i], 1'b1});
            wt(70);
            chk("trip_early", 32'h0, trip);
            wt(80);
            chk("trip", {31'h0, texp[i]}, trip);
            chk("fault", texp[i] ? 32'h1 : 32'h0, fault);
            if (texp[i])
            begin
                rd("status_trip", `PBS_ADR_STATUS, 32'h107);
                wr(`PBS_ADR_CTRL, 32'h4);
                wt(2);
                chk("trip_clear", 32'h0, trip);
            end
        end
        slow <= 1'b0;
    endtask
    task automatic t_standby;
        wr(`PBS_ADR_CTRL, 32'h0);
        wr(`PBS_ADR_PRIME, 32'h0);
        wr(`PBS_ADR_BURST, 32'h3E8);
        wr(`PBS_ADR_SBY_SPEED, 32'h64);
        wr(`PBS_ADR_SBY_DELAY, 32'h0);
        pid_ref <= 16'h0258;
        fb_set <= 16'h024E;
        speed_set <= 16'h0032;
        wr(`PBS_ADR_CTRL, 32'h1);
        wt(100);
        chk("standby_zero_delay", 32'h0, standby);
        chk("no_prime_no_trip", 32'h0, trip);
        wr(`PBS_ADR_SBY_DELAY, 32'h3);
        wt(60);
        chk("standby_entry", 32'h1, standby);
        wt(30);
        chk("standby_small_err", 32'h1, standby);
        fb_set <= 16'h01F4;
        wt(4);
        chk("standby_restart", 32'h0, standby);
        speed_set <= 16'h00C8;
        wt(60);
        chk("standby_fast", 32'h0, standby);
        wr(`PBS_ADR_CTRL, 32'h0);
    endtask
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_display();
        t_preset();
        t_prime();
        t_standby();
        stop_test();
    end
endmodule
